// ==== src/srws_wake.sv ====
`timescale 1ns/1ps
// What this block does
// - First selector wakes when chosen combination equals its level bit.
// - First selector codes 000 and reserved 001 give no event.
// - First selector ignores output pins and pins used by change detectors.
// - Enabled port 2 pin wakes on zero level while no reference latched.
// - Port 2 data read or write latches reference; wake on mismatch.
// - Port 2 status shows 01 read, 10 write; clear restores zero trigger.
// - Second selector codes 001 to 100 pick fixed NAND/NOR combinations.
// - Codes 101 to 111 combine port 3 with port 0 or port 2 pins.
// - Second selector wakes when combination equals its level bit.
// - Second selector ignores output pins and detector-enabled pins.
// - Wake request is OR of all enabled sources.
// - Configuration survives stop recovery; only other resets clear it.
// - Port 3 pins 0-3 individually enabled; zero level wakes by default.
// - Port data access latches port 3 reference; wake on mismatch.
// - Port 3 status shows 01 read, 10 write; clear restores zero trigger.
// - Fifth register holds interrupt routing enable and both status fields.
// - With routing enabled, wake drives irq one and reads port3 pin3 as 0.
module srws_wake
	import srws_pkg::*;
(
	input  wire logic        clock,           // 200 MHz system clock
	input  wire logic        sys_rst,         // Non-recovery reset, active high
	input  wire logic        stop_recovery,   // Recovery reset, leaves config intact
	input  wire logic [11:0] reg_addr,        // CPU register address
	input  wire logic        reg_wr,          // Write strobe
	input  wire logic        reg_rd,          // Read strobe
	input  wire logic [7:0]  reg_wdata,       // Write data
	output logic      [7:0]  reg_rdata,       // Read data
	input  wire logic [7:0]  port0_pins,      // Port 0 pin levels
	input  wire logic [7:0]  port2_pins,      // Port 2 pin levels
	input  wire logic [3:0]  port3_pins,      // Port 3 pin levels
	input  wire logic [7:0]  port2_dir_out,   // Port 2 pins set as outputs
	input  wire logic [7:0]  port0_dir_out,   // Port 0 pins set as outputs
	input  wire logic [7:0]  port2_data_reg,  // Port 2 output latch value
	input  wire logic [3:0]  port3_data_reg,  // Port 3 output latch value
	output logic             wake_async,      // Combinational wake request
	output logic             wake_sync,       // Synchronized wake level
	output logic             external_irq_one,// Routed wake interrupt
	output logic             port3_pin3_read  // Port 3 pin 3 as read by CPU
);
	logic [7:0] sel1_q, sel1_d, sel2_q, sel2_d;
	logic [7:0] p2en_q, p2en_d, route_q, route_d;
	logic [3:0] p3en_q, p3en_d;
	logic [7:0] p2ref_q, p2ref_d;
	logic [3:0] p3ref_q, p3ref_d;
	logic [1:0] sync_q, sync_d;
	logic [7:0] p2_pin_s1_q, p2_pin_s1_d, p2_pin_s2_q, p2_pin_s2_d;
	logic [3:0] p3_pin_s1_q, p3_pin_s1_d, p3_pin_s2_q, p3_pin_s2_d;
	logic [7:0] p2_use;
	logic [3:0] p3_use;
	logic [7:0] p0_use;
	logic [7:0] p2_mis;
	logic [3:0] p3_mis;
	logic       sel1_out, sel2_out, sel1_ev, sel2_ev, chg_ev;
	logic [2:0] sel1_src, sel2_src;
	logic [1:0] p2st, p3st;
	logic       p2_acc, p3_acc;

	// NAND over a masked group: ignored pins count as 1
	function automatic logic nand_m(input logic [7:0] v, input logic [7:0] m);
		nand_m = ~&(v | ~m);
	endfunction
	// NOR over a masked group: ignored pins count as 0
	function automatic logic nor_m(input logic [7:0] v, input logic [7:0] m);
		nor_m = ~|(v & m);
	endfunction

	// Status 00 means no reference taken: zero level wakes
	function automatic logic ref_none(input logic [1:0] st);
		ref_none = (st == SRWS_REF_NONE);
	endfunction

	assign p2_use = ~port2_dir_out & ~p2en_q;
	assign p3_use = ~p3en_q;
	assign p0_use = ~port0_dir_out;

	assign sel1_src = sel1_q[SRWS_SRC_MSB:SRWS_SRC_LSB];
	assign sel2_src = sel2_q[SRWS_SRC_MSB:SRWS_SRC_LSB];
	assign p2st     = route_q[SRWS_P2ST_LSB+1:SRWS_P2ST_LSB];
	assign p3st     = route_q[SRWS_P3ST_LSB+1:SRWS_P3ST_LSB];

	always_comb begin
		sel1_out = 1'b0;
		unique case (sel1_src)
			SRWS_SRC_NONE, SRWS_S1_RSVD: sel1_out = 1'b0;
			SRWS_S1_P30:      sel1_out = port3_pins[1] | ~p3_use[1];
			SRWS_S1_P31:      sel1_out = port3_pins[2] | ~p3_use[2];
			SRWS_S1_P32:      sel1_out = port3_pins[3] | ~p3_use[3];
			SRWS_S1_NAND_P2L: sel1_out = nand_m(port2_pins, p2_use & 8'h0f);
			SRWS_S1_NAND_P2:  sel1_out = nand_m(port2_pins, p2_use);
			SRWS_S1_NOR_P2:   sel1_out = nor_m(port2_pins, p2_use);
		endcase
		sel1_ev = (sel1_src != SRWS_SRC_NONE) && (sel1_src != SRWS_S1_RSVD) &&
			(sel1_out == sel1_q[SRWS_LEVEL_BIT]);
	end

	always_comb begin
		logic [7:0] p3v, p3m, p30v, p30m, p32v, p32m;
		p3v  = {5'h00, port3_pins[3:1]};
		p3m  = {5'h00, p3_use[3:1]};
		p30v = {3'h0, port0_pins[7], port0_pins[0], port3_pins[3:1]};
		p30m = {3'h0, p0_use[7], p0_use[0], p3_use[3:1]};
		p32v = {2'h0, port2_pins[2:0], port3_pins[3:1]};
		p32m = {2'h0, p2_use[2:0], p3_use[3:1]};
		sel2_out = 1'b0;
		unique case (sel2_src)
			SRWS_SRC_NONE:     sel2_out = 1'b0;
			SRWS_SRC_NAND_P2L: sel2_out = nand_m(port2_pins, p2_use & 8'h0f);
			SRWS_SRC_NAND_P2:  sel2_out = nand_m(port2_pins, p2_use);
			SRWS_SRC_NOR_P3:   sel2_out = nor_m(p3v, p3m);
			SRWS_SRC_NAND_P3:  sel2_out = nand_m(p3v, p3m);
			SRWS_SRC_NOR_P30:  sel2_out = nor_m(p30v, p30m);
			SRWS_SRC_NAND_P30: sel2_out = nand_m(p30v, p30m);
			SRWS_SRC_NAND_P32: sel2_out = nand_m(p32v, p32m);
		endcase
		sel2_ev = (sel2_src != SRWS_SRC_NONE) && (sel2_out == sel2_q[SRWS_LEVEL_BIT]);
	end

	for (genvar i = 0; i < 8; i++) begin : g_p2_pin
		assign p2_mis[i] = ref_none(p2st) ? ~port2_pins[i] : (port2_pins[i] ^ p2ref_q[i]);
	end

	for (genvar i = 0; i < 4; i++) begin : g_p3_pin
		assign p3_mis[i] = ref_none(p3st) ? ~port3_pins[i] : (port3_pins[i] ^ p3ref_q[i]);
	end

	assign chg_ev = |(p2_mis & p2en_q) | |(p3_mis & p3en_q);

	assign wake_async = sel1_ev | sel2_ev | chg_ev;

	assign external_irq_one = route_q[SRWS_ROUTE_BIT] & wake_sync;
	assign port3_pin3_read  = (route_q[SRWS_ROUTE_BIT] & wake_sync) ? 1'b0 : port3_pins[3];

	assign p2_acc = (reg_addr == SRWS_ADDR_P2_DATA) && (reg_rd || reg_wr);
	assign p3_acc = (reg_addr == SRWS_ADDR_P3_DATA) && (reg_rd || reg_wr);

	// Register next values
	always_comb begin
		sel1_d  = sel1_q;
		sel2_d  = sel2_q;
		p2en_d  = p2en_q;
		p3en_d  = p3en_q;
		route_d = route_q;
		p2ref_d = p2ref_q;
		p3ref_d = p3ref_q;
		sync_d  = {sync_q[0], wake_async};
		// Port levels cross into the clock domain before any latch reads them
		p2_pin_s1_d = port2_pins;
		p2_pin_s2_d = p2_pin_s1_q;
		p3_pin_s1_d = port3_pins;
		p3_pin_s2_d = p3_pin_s1_q;
		if (reg_wr) begin
			unique case (reg_addr)
				SRWS_ADDR_SEL_ONE: sel1_d = reg_wdata;
				SRWS_ADDR_SEL_TWO: sel2_d = reg_wdata;
				SRWS_ADDR_P2_EN:   p2en_d = reg_wdata;
				SRWS_ADDR_P3_EN:   p3en_d = reg_wdata[3:0];
				SRWS_ADDR_ROUTE_ST: route_d = reg_wdata;
				default: ;
			endcase
		end
		if (p2_acc && |p2en_q) begin
			p2ref_d = reg_wr ? port2_data_reg : p2_pin_s2_q;
			route_d[SRWS_P2ST_LSB+1:SRWS_P2ST_LSB] = reg_wr ? SRWS_REF_WRITE : SRWS_REF_READ;
		end
		if (p3_acc && |p3en_q) begin
			p3ref_d = reg_wr ? port3_data_reg : p3_pin_s2_q;
			route_d[SRWS_P3ST_LSB+1:SRWS_P3ST_LSB] = reg_wr ? SRWS_REF_WRITE : SRWS_REF_READ;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sel1_q  <= SRWS_RST_BYTE;
			sel2_q  <= SRWS_SEL2_RSVD_ONE;
			p2en_q  <= SRWS_RST_BYTE;
			p3en_q  <= SRWS_RST_BYTE[3:0];
			route_q <= SRWS_RST_BYTE;
			p2ref_q <= SRWS_RST_BYTE;
			p3ref_q <= SRWS_RST_BYTE[3:0];
			sync_q  <= SRWS_RST_BYTE[1:0];
			p2_pin_s1_q <= SRWS_RST_BYTE;
			p2_pin_s2_q <= SRWS_RST_BYTE;
			p3_pin_s1_q <= SRWS_RST_BYTE[3:0];
			p3_pin_s2_q <= SRWS_RST_BYTE[3:0];
		end else begin
			sel1_q  <= sel1_d;
			sel2_q  <= sel2_d;
			p2en_q  <= p2en_d;
			p3en_q  <= p3en_d;
			route_q <= route_d;
			p2ref_q <= p2ref_d;
			p3ref_q <= p3ref_d;
			sync_q  <= sync_d;
			p2_pin_s1_q <= p2_pin_s1_d;
			p2_pin_s2_q <= p2_pin_s2_d;
			p3_pin_s1_q <= p3_pin_s1_d;
			p3_pin_s2_q <= p3_pin_s2_d;
		end
	end
	assign wake_sync = sync_q[1];

	always_comb begin
		unique case (reg_addr)
			SRWS_ADDR_SEL_ONE:  reg_rdata = sel1_q;
			SRWS_ADDR_SEL_TWO:  reg_rdata = sel2_q;
			SRWS_ADDR_P2_EN:    reg_rdata = p2en_q;
			SRWS_ADDR_P3_EN:    reg_rdata = {4'h0, p3en_q};
			SRWS_ADDR_ROUTE_ST: reg_rdata = route_q;
			default:            reg_rdata = SRWS_RST_BYTE;
		endcase
	end

	a_wake_or_sources: assert property (@(posedge clock) disable iff (sys_rst)
		(!sel1_ev && !sel2_ev && !(|{p2en_q, p3en_q})) |-> !wake_async)
		else $error("wake without source");
	a_wake_sync_lag: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(wake_async) ##0 wake_async[*2] |=> wake_sync)
		else $error("wake sync late");
	a_sel1_reserved: assert property (@(posedge clock) disable iff (sys_rst)
		(sel1_src == SRWS_S1_RSVD) |-> !sel1_ev)
		else $error("reserved code woke");
	a_p2_wr_status: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_wr && reg_addr == SRWS_ADDR_P2_DATA && |p2en_q) |=> p2st == SRWS_REF_WRITE)
		else $error("p2 write status wrong");
	a_p3_rd_status: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_rd && !reg_wr && p3_acc && |p3en_q) |=> p3st == SRWS_REF_READ)
		else $error("p3 read status wrong");
	a_p3_rd_ref: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_rd && !reg_wr && p3_acc && |p3en_q) |=> p3ref_q == $past(p3_pin_s2_q))
		else $error("p3 read reference wrong");
	a_p2_zero_trig: assert property (@(posedge clock) disable iff (sys_rst)
		(p2st == SRWS_REF_NONE && |(p2en_q & ~port2_pins)) |-> wake_async)
		else $error("p2 zero missed");
	a_p2_ref_mis: assert property (@(posedge clock) disable iff (sys_rst)
		(p2st != SRWS_REF_NONE && |(p2en_q & (port2_pins ^ p2ref_q))) |-> wake_async)
		else $error("p2 mismatch missed");
	a_irq_route: assert property (@(posedge clock) disable iff (sys_rst)
		external_irq_one |-> route_q[SRWS_ROUTE_BIT] && !port3_pin3_read)
		else $error("irq route wrong");
	a_sel2_level: assert property (@(posedge clock) disable iff (sys_rst)
		(sel2_src == SRWS_SRC_NAND_P2 && &{p2_use, port2_pins}
		&& !sel2_q[SRWS_LEVEL_BIT]) |-> sel2_ev) else $error("level compare wrong");
	a_keep_config: assert property (@(posedge clock) disable iff (sys_rst)
		(stop_recovery && !reg_wr) |=> $stable(sel2_q) && $stable(p2en_q))
		else $error("config lost");
	a_sel1_level: assert property (@(posedge clock) disable iff (sys_rst)
		(sel1_src == SRWS_S1_P30 && p3_use[1]
		&& port3_pins[1] == sel1_q[SRWS_LEVEL_BIT]) |-> wake_async) else $error("sel1 missed");
	a_sel1_none: assert property (@(posedge clock) disable iff (sys_rst)
		(sel1_src == SRWS_SRC_NONE) |-> !sel1_ev)
		else $error("first selector idle woke");
	a_sel1_excl: assert property (@(posedge clock) disable iff (sys_rst)
		(sel1_src == SRWS_S1_NAND_P2 && !p2_use[0]
		&& &{port2_pins[7:1], p2_use[7:1]}) |-> !sel1_out) else $error("sel1 used ignored pin");
	a_sel2_none: assert property (@(posedge clock) disable iff (sys_rst)
		(sel2_src == SRWS_SRC_NONE) |-> !sel2_ev)
		else $error("second selector idle woke");
	a_sel2_nor_p3: assert property (@(posedge clock) disable iff (sys_rst)
		(sel2_src == SRWS_SRC_NOR_P3 && p3_use[1] && port3_pins[1]) |-> !sel2_out)
		else $error("port 3 NOR wrong");
	a_sel2_nor_p30: assert property (@(posedge clock) disable iff (sys_rst)
		(sel2_src == SRWS_SRC_NOR_P30 && p0_use[0] && port0_pins[0]) |-> !sel2_out)
		else $error("port 0 NOR wrong");
	a_sel2_nand_p32: assert property (@(posedge clock) disable iff (sys_rst)
		(sel2_src == SRWS_SRC_NAND_P32 && p2_use[0] && !port2_pins[0]) |-> sel2_out)
		else $error("port 2 NAND wrong");
	a_sel2_excl: assert property (@(posedge clock) disable iff (sys_rst)
		(sel2_src == SRWS_SRC_NAND_P2L && !p2_use[0]
		&& &{port2_pins[3:1], p2_use[3:1]}) |-> !sel2_out) else $error("sel2 used ignored pin");
	a_p3_zero_trig: assert property (@(posedge clock) disable iff (sys_rst)
		(p3st == SRWS_REF_NONE && |(p3en_q & ~port3_pins)) |-> wake_async)
		else $error("p3 zero missed");
	a_p3_ref_mis: assert property (@(posedge clock) disable iff (sys_rst)
		(p3st != SRWS_REF_NONE && |(p3en_q & (port3_pins ^ p3ref_q))) |-> wake_async)
		else $error("p3 mismatch missed");
	a_p2_rd_status: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_rd && !reg_wr && p2_acc && |p2en_q) |=> p2st == SRWS_REF_READ)
		else $error("p2 read status wrong");
	a_p3_wr_status: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_wr && p3_acc && |p3en_q) |=> p3st == SRWS_REF_WRITE)
		else $error("p3 write status wrong");
	a_p2_ref_latch: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_wr && p2_acc && |p2en_q) |=> p2ref_q == $past(port2_data_reg))
		else $error("p2 write reference wrong");
	a_p3_ref_latch: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_wr && p3_acc && |p3en_q) |=> p3ref_q == $past(port3_data_reg))
		else $error("p3 write reference wrong");
	a_p2_clear: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_wr && reg_addr == SRWS_ADDR_ROUTE_ST && reg_wdata[1:0] == SRWS_REF_NONE)
		|=> p2st == SRWS_REF_NONE) else $error("p2 clear lost");
	a_p3_clear: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_wr && reg_addr == SRWS_ADDR_ROUTE_ST && reg_wdata[3:2] == SRWS_REF_NONE)
		|=> p3st == SRWS_REF_NONE) else $error("p3 clear lost");
	a_route_rd: assert property (@(posedge clock) disable iff (sys_rst)
		(reg_addr == SRWS_ADDR_ROUTE_ST) |-> reg_rdata == route_q)
		else $error("route read-back wrong");
	a_irq_off: assert property (@(posedge clock) disable iff (sys_rst)
		!route_q[SRWS_ROUTE_BIT] |-> !external_irq_one && port3_pin3_read == port3_pins[3])
		else $error("unrouted wake leaked");
	a_sync_fall: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(wake_async) ##0 !wake_async[*2] |=> !wake_sync)
		else $error("wake sync stuck");
	a_keep_route: assert property (@(posedge clock) disable iff (sys_rst)
		(stop_recovery && !reg_wr && !reg_rd)
		|=> $stable(route_q) && $stable(p3en_q)) else $error("route lost");
endmodule // srws_wake

// ==== src/srws_pkg.sv ====
package srws_pkg;
	// Register addresses (linear)
	localparam logic [11:0] SRWS_ADDR_SEL_ONE   = 12'hf0b;
	localparam logic [11:0] SRWS_ADDR_P2_EN     = 12'hf0c;
	localparam logic [11:0] SRWS_ADDR_SEL_TWO   = 12'hf0d;
	localparam logic [11:0] SRWS_ADDR_P3_EN     = 12'hf0e;
	localparam logic [11:0] SRWS_ADDR_ROUTE_ST  = 12'hf0f;
	localparam logic [11:0] SRWS_ADDR_P2_DATA   = 12'h002;
	localparam logic [11:0] SRWS_ADDR_P3_DATA   = 12'h003;
	// Field positions
	localparam int SRWS_LEVEL_BIT   = 6;
	localparam int SRWS_SRC_LSB     = 2;
	localparam int SRWS_SRC_MSB     = 4;
	localparam int SRWS_ROUTE_BIT   = 4;
	localparam int SRWS_P3ST_LSB    = 2;
	localparam int SRWS_P2ST_LSB    = 0;
	localparam int SRWS_P3_WAKE_PIN = 3;
	// Reference status codes
	localparam logic [1:0] SRWS_REF_NONE  = 2'h0;
	localparam logic [1:0] SRWS_REF_READ  = 2'h1;
	localparam logic [1:0] SRWS_REF_WRITE = 2'h2;
	// Source codes of the second selector
	localparam logic [2:0] SRWS_SRC_NONE     = 3'h0;
	localparam logic [2:0] SRWS_SRC_NAND_P2L = 3'h1;
	localparam logic [2:0] SRWS_SRC_NAND_P2  = 3'h2;
	localparam logic [2:0] SRWS_SRC_NOR_P3   = 3'h3;
	localparam logic [2:0] SRWS_SRC_NAND_P3  = 3'h4;
	localparam logic [2:0] SRWS_SRC_NOR_P30  = 3'h5;
	localparam logic [2:0] SRWS_SRC_NAND_P30 = 3'h6;
	localparam logic [2:0] SRWS_SRC_NAND_P32 = 3'h7;
	// First selector codes; 001 reserved
	localparam logic [2:0] SRWS_S1_RSVD      = 3'h1;
	localparam logic [2:0] SRWS_S1_P30       = 3'h2;
	localparam logic [2:0] SRWS_S1_P31       = 3'h3;
	localparam logic [2:0] SRWS_S1_P32       = 3'h4;
	localparam logic [2:0] SRWS_S1_NAND_P2L  = 3'h5;
	localparam logic [2:0] SRWS_S1_NAND_P2   = 3'h6;
	localparam logic [2:0] SRWS_S1_NOR_P2    = 3'h7;
	// Reset values
	localparam logic [7:0] SRWS_RST_BYTE = 8'h00;
	localparam logic [7:0] SRWS_SEL2_RSVD_ONE = 8'h20;
endpackage

// ==== bench/srws_port_model.sv ====
`timescale 1ns/1ps
module srws_port_model (
	input  wire logic [7:0] lvl0,       // Level applied to port 0
	input  wire logic [7:0] lvl2,       // Level applied to port 2
	input  wire logic [3:0] lvl3,       // Level applied to port 3
	input  wire logic [7:0] p2_out,     // Port 2 pins set as outputs
	input  wire logic [7:0] p2_latch,   // Port 2 output latch
	output logic      [7:0] port0_pins, // Port 0 pin levels
	output logic      [7:0] port2_pins, // Port 2 pin levels
	output logic      [3:0] port3_pins  // Port 3 pin levels
);
	assign port0_pins = lvl0;
	assign port2_pins = (p2_out & p2_latch) | (~p2_out & lvl2);
	assign port3_pins = lvl3;
endmodule // srws_port_model

// ==== bench/tb_stop_recovery_wake_sources.sv ====
`timescale 1ns/1ps
module tb_stop_recovery_wake_sources;
	import srws_pkg::*;
	logic        clock = 0, sys_rst = 1, stop_recovery = 0, reg_wr = 0, reg_rd = 0;
	logic [11:0] reg_addr = 0;
	logic [7:0]  reg_wdata = 0, reg_rdata, rv, lvl0 = 8'hff, lvl2 = 8'hff;
	logic [7:0]  p2_out = 0, p0_out = 0, p2_latch = 0, port0_pins, port2_pins;
	logic [3:0]  lvl3 = 4'hf, p3_latch = 0, port3_pins;
	logic        wake_async, wake_sync, external_irq_one, port3_pin3_read, e;
	int          failures = 0, checked = 0, cycles = 0;
	srws_wake uut (.clock, .sys_rst, .stop_recovery, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .port0_pins, .port2_pins, .port3_pins, .port2_dir_out(p2_out),
		.port0_dir_out(p0_out), .port2_data_reg(p2_latch), .port3_data_reg(p3_latch),
		.wake_async, .wake_sync, .external_irq_one, .port3_pin3_read);
	srws_port_model pm (.lvl0, .lvl2, .lvl3, .p2_out, .p2_latch, .port0_pins, .port2_pins,
		.port3_pins);
	always #2.5 clock = ~clock;
	task give_verdict();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			give_verdict();
		end
	end
	task chk(input string n, input logic [7:0] ex, input logic [7:0] s);
		checked++;
		if (s !== ex) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, ex, s);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a; reg_wdata = d; reg_wr = 1;
		@(negedge clock);
		reg_wr = 0;
	endtask
	task rd(input logic [11:0] a);
		@(negedge clock);
		reg_addr = a; reg_rd = 1;
		#1 rv = reg_rdata;
		@(negedge clock);
		reg_rd = 0;
	endtask
	task wk(input logic x);
		#1 chk("wake_async", {7'h00, x}, {7'h00, wake_async});
	endtask
	function automatic logic combo2(input logic [2:0] c);
		case (c)
			3'h1: return ~&lvl2[3:0];
			3'h2: return ~&lvl2;
			3'h3: return ~|lvl3[3:1];
			3'h4: return ~&lvl3[3:1];
			3'h5: return ~|{lvl3[3:1], lvl0[0], lvl0[7]};
			3'h6: return ~&{lvl3[3:1], lvl0[0], lvl0[7]};
			default: return ~&{lvl3[3:1], lvl2[2:0]};
		endcase
	endfunction
	initial begin
		repeat (20) @(negedge clock);
		sys_rst = 0;
		rd(SRWS_ADDR_SEL_ONE); chk("sel_one", 8'h00, rv);
		rd(SRWS_ADDR_ROUTE_ST); chk("route_st", 8'h00, rv);
		chk("pin3_read", 8'h01, {7'h00, port3_pin3_read});
		rd(SRWS_ADDR_SEL_TWO); chk("sel_two", 8'h00, rv & 8'h5c);
		rd(12'h100); chk("unmapped", 8'h00, rv);
		$display("done: reset values");
		for (int p = 0; p < 2; p++) for (int l = 0; l < 2; l++) for (int c = 0; c < 8; c++) begin
			lvl0 = p ? 8'h00 : 8'h81; lvl2 = p ? 8'hff : 8'hf0; lvl3 = p ? 4'h0 : 4'he;
			e = (c != 0) && (combo2(3'(c)) == 1'(l));
			wr(SRWS_ADDR_SEL_TWO, {1'b0, 1'(l), 1'b1, 3'(c), 2'b00});
			wk(e);
		end
		lvl2 = 8'hfe; wr(SRWS_ADDR_SEL_TWO, 8'h64); wk(1);
		p2_out = 8'h01; wk(0);
		wr(SRWS_ADDR_SEL_TWO, 8'h20); p2_out = 0; lvl2 = 8'h00; lvl3 = 4'h0;
		wr(SRWS_ADDR_SEL_ONE, 8'h00); wk(0);
		wr(SRWS_ADDR_SEL_ONE, 8'h04); wk(0);
		wr(SRWS_ADDR_SEL_ONE, 8'h08); wk(1);
		lvl3 = 4'h2; wk(0);
		lvl2 = 8'hfe; wr(SRWS_ADDR_SEL_ONE, 8'h58); wk(1);
		p2_out = 8'h01; wk(0);
		wr(SRWS_ADDR_SEL_ONE, 8'h00); p2_out = 0; lvl2 = 8'hff; lvl3 = 4'hf;
		$display("done: selectors");
		wr(SRWS_ADDR_P2_EN, 8'h01); wk(0);
		lvl2 = 8'hfe; wk(1);
		wr(SRWS_ADDR_P2_DATA, 8'h00); rd(SRWS_ADDR_ROUTE_ST);
		chk("p2_status", 8'h02, rv & 8'h03);
		lvl2 = 8'hff; wk(1);
		repeat (2) @(negedge clock);
		rd(SRWS_ADDR_P2_DATA); rd(SRWS_ADDR_ROUTE_ST);
		chk("p2_status", 8'h01, rv & 8'h03); wk(0);
		lvl2 = 8'hfe; wk(1);
		wr(SRWS_ADDR_ROUTE_ST, 8'h00); lvl2 = 8'hff; wk(0);
		wr(SRWS_ADDR_P2_EN, 8'h00);
		$display("done: port 2 detector");
		wr(SRWS_ADDR_P3_EN, 8'h01); wk(0);
		lvl3 = 4'he; wk(1);
		wr(SRWS_ADDR_ROUTE_ST, 8'h10); wr(SRWS_ADDR_P3_DATA, 8'h00);
		rd(SRWS_ADDR_ROUTE_ST); chk("route_st", 8'h18, rv & 8'h1f);
		lvl3 = 4'hf; wk(1);
		repeat (3) @(negedge clock);
		chk("wake_sync", 8'h01, {7'h00, wake_sync});
		chk("irq_one", 8'h01, {7'h00, external_irq_one});
		chk("pin3_read", 8'h00, {7'h00, port3_pin3_read});
		rd(SRWS_ADDR_P3_DATA); rd(SRWS_ADDR_ROUTE_ST); wk(0);
		chk("route_st", 8'h14, rv & 8'h1f);
		$display("done: port 3 detector and routing");
		stop_recovery = 1; repeat (2) @(negedge clock); stop_recovery = 0;
		rd(SRWS_ADDR_P3_EN); chk("p3_en", 8'h01, rv);
		rd(SRWS_ADDR_ROUTE_ST); chk("route_st", 8'h14, rv & 8'h1f);
		sys_rst = 1; @(negedge clock); sys_rst = 0;
		rd(SRWS_ADDR_P3_EN); chk("p3_en", 8'h00, rv);
		$display("done: retention");
		give_verdict();
	end
endmodule // tb_stop_recovery_wake_sources
